// File: design/link_defines.svh
// Offsets, field codes, telegram lengths and timing counts of the supply-line telegram link.
// Assumes a 200 MHz register clock; every count below is derived from that rate.
`ifndef LINK_DEFINES_SVH
`define LINK_DEFINES_SVH
// ****************************************************************************
// Clock and link timing.
// ****************************************************************************
`define CLK_PERIOD_NS 5
`define SYNC_MIN_US 1700
`define SYNC_MAX_US 1800
`define OUT_PERIOD_US 3000
`define ACT_MIN_US 50
`define ACT_MAX_US 200
`define BURN_WAIT_US 2000
`define STARTUP_US 20
`define CEIL_CYC(us) (((us) * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FLOOR_CYC(us) (((us) * 1000) / `CLK_PERIOD_NS)
`define SYNC_MIN_CYC `CEIL_CYC(`SYNC_MIN_US)
`define SYNC_MAX_CYC `FLOOR_CYC(`SYNC_MAX_US)
`define OUT_PERIOD_CYC `FLOOR_CYC(`OUT_PERIOD_US)
`define ACT_MIN_CYC `CEIL_CYC(`ACT_MIN_US)
`define ACT_MAX_CYC `FLOOR_CYC(`ACT_MAX_US)
`define BURN_WAIT_CYC `FLOOR_CYC(`BURN_WAIT_US)
`define STARTUP_CYC `CEIL_CYC(`STARTUP_US)
// ****************************************************************************
// APB register offsets and telegram codes.
// ****************************************************************************
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_ADC 12'h008
`define OFS_REGS 12'h040
`define CMD_READ 3'h2
`define CMD_WRITE 3'h3
`define CMD_BURN 3'h4
`define CMD_ERASE 3'h5
`define CMD_FLOCK 3'h6
`define CMD_LOCK 3'h7
`define SEL_LOCK 4'h6
`define SEL_ADC 4'h7
`define SEL_FLOCK 4'hE
`define SEL_DEACT 4'hF
`define DEACT_VALUE 14'h080F
`define HDR_BITS 5'd9
`define WR_BITS 5'd24
`endif

// File: design/link_pkg.sv
// Types shared by the supply-line telegram link.
// Assumes link_defines.svh is compiled alongside for the numeric constants.
package link_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SYNC = 3'b001,
      ST_BITS = 3'b010,
      ST_EXEC = 3'b011,
      ST_TX = 3'b100,
      ST_BURN = 3'b101,
      ST_START = 3'b110
   } rx_state_t;
   typedef struct packed {
      logic [1:0] sup_s, pin_s, uv_s, hold_s, prog_s;
      logic sup_prev, pin_prev;
      rx_state_t st;
      logic [19:0] tbit, cnt, tx_cnt, act_cnt, obit;
      logic mid_seen, tx_mid, burn_pend, burn_erase;
      logic [4:0] nbits, tx_left;
      logic [23:0] shreg;
      logic [15:0] tx_sh;
      logic [13:0] adc;
      logic active, dev_lock, fac_lock;
      logic [223:0] ram, nv;
      logic out_drive, out_oe, analog_only, analog_hold, burn_busy;
      logic [31:0] prdata;
      logic pready, pslverr;
   } link_state_t;
endpackage : link_pkg

// File: design/supply_line_telegram_link.sv
// Telegram receiver and replier of a programmable sensor, with its register RAM, its
// nonvolatile image, the activate selector and undervoltage handling, plus an APB slave.
// Assumes comparator outputs on the supply and the output pin arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
`include "link_defines.svh"
module supply_line_telegram_link import link_pkg::*; #(
   parameter int unsigned SYNC_MIN_CYC = `SYNC_MIN_CYC,
   parameter int unsigned SYNC_MAX_CYC = `SYNC_MAX_CYC,
   parameter int unsigned OUT_PERIOD_CYC = `OUT_PERIOD_CYC,
   parameter int unsigned ACT_MIN_CYC = `ACT_MIN_CYC,
   parameter int unsigned ACT_MAX_CYC = `ACT_MAX_CYC,
   parameter int unsigned BURN_WAIT_CYC = `BURN_WAIT_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic supply_level,
   input wire logic supply_above_digital,
   input wire logic supply_above_hold,
   input wire logic supply_at_prog,
   input wire logic out_pin_in,
   output logic out_pin_out,
   output logic out_pin_oe,
   output logic analog_only,
   output logic analog_hold,
   output logic burn_busy
);
   localparam int unsigned STARTUP_CYC = `STARTUP_CYC;

   // ****************************************************************************
   // Elaboration checks.
   // ****************************************************************************
   // Counters are 20 bits wide and the bit-phase arithmetic needs at least 16 cycles.
   if (SYNC_MAX_CYC >= 2**20 || OUT_PERIOD_CYC >= 2**20 || BURN_WAIT_CYC >= 2**20 ||
       ACT_MAX_CYC >= 2**20 || SYNC_MIN_CYC < 16 || OUT_PERIOD_CYC < 16 ||
       SYNC_MIN_CYC > SYNC_MAX_CYC || ACT_MIN_CYC > ACT_MAX_CYC) begin : g_bad
      $error("supply_line_telegram_link: timing parameter out of range");
   end

   // ****************************************************************************
   // Register-table helpers.
   // ****************************************************************************
   // Bit width of each selectable register; zero marks a hole in the map.
   function automatic logic [3:0] sel_width(input logic [3:0] sel);
      case (sel)
         4'h1: sel_width = 4'd10;
         4'h2, 4'h3: sel_width = 4'd11;
         4'h4, 4'h7: sel_width = 4'd14;
         4'h5, 4'hB, 4'hD: sel_width = 4'd6;
         4'h6, 4'hE: sel_width = 4'd1;
         4'h8: sel_width = 4'd4;
         4'h9, 4'hC: sel_width = 4'd5;
         4'hF: sel_width = 4'd12;
         default: sel_width = 4'd0;
      endcase
   endfunction : sel_width

   link_state_t q;
   link_state_t d;
   localparam link_state_t RST = '{st: ST_START, obit: 20'(OUT_PERIOD_CYC), active: 1'b1,
                                   fac_lock: 1'b1, default: '0};

   // ****************************************************************************
   // Telegram decode, visible to the state update and to the checks.
   // ****************************************************************************
   logic sup_edge;
   logic is_long;
   logic [8:0] hdr;
   logic [2:0] cmd;
   logic [3:0] sel;
   logic [13:0] pay;
   logic [3:0] wid;
   logic [13:0] wmask;
   logic hdr_ok;
   logic pay_ok;
   logic sel_wr;
   logic [13:0] rd_val;
   logic [13:0] rd_word;
   assign sup_edge = q.sup_s[1] ^ q.sup_prev;
   assign is_long = (q.nbits == `WR_BITS);
   assign hdr = is_long ? q.shreg[23:15] : q.shreg[8:0];
   assign cmd = hdr[8:6];
   assign sel = hdr[4:1];
   assign pay = q.shreg[14:1];
   assign wid = sel_width(sel);
   assign wmask = 14'h3FFF >> (4'd14 - wid);
   assign hdr_ok = (hdr[5] == ^(~cmd)) && (hdr[0] == ^(~sel));
   assign pay_ok = is_long && (q.shreg[0] == ~^(~pay));
   // Factory registers only take writes while the factory lock is clear, which never happens.
   assign sel_wr = (wid != 4'd0) && (sel != `SEL_LOCK) && (sel != `SEL_ADC) &&
                   (sel != `SEL_FLOCK) && (!q.fac_lock || (sel != 4'h8 && sel != 4'h9 &&
                   sel != 4'hD));
   assign rd_val = (sel == `SEL_ADC) ? q.adc : (sel == `SEL_LOCK) ? {13'h0000, q.dev_lock} :
                   (sel == `SEL_FLOCK) ? {13'h0000, q.fac_lock} : q.ram[sel*14 +: 14];
   assign rd_word = rd_val << (4'd14 - wid);

   // ****************************************************************************
   // Next-state logic.
   // ****************************************************************************
   // The whole block is one state record; this process computes its successor.
   always_comb begin
      logic ack;
      logic [4:0] nb;
      logic [23:0] sh;
      logic [13:0] pw;
      ack = 1'b0;
      nb = q.nbits + 5'd1;
      sh = {q.shreg[22:0], q.mid_seen};
      pw = pay & wmask;
      d = q;
      d.sup_s = {q.sup_s[0], supply_level};
      d.pin_s = {q.pin_s[0], out_pin_in};
      d.uv_s = {q.uv_s[0], supply_above_digital};
      d.hold_s = {q.hold_s[0], supply_above_hold};
      d.prog_s = {q.prog_s[0], supply_at_prog};
      d.sup_prev = q.sup_s[1];
      d.pin_prev = q.pin_s[1];
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      d.analog_only = q.dev_lock;
      d.fac_lock = 1'b1;
      case (q.st)
         ST_START: begin
            d.cnt = q.cnt + 20'd1;
            if (q.cnt >= 20'(STARTUP_CYC - 1)) begin
               d.st = ST_IDLE;
               d.cnt = '0;
            end
         end
         ST_IDLE: begin
            d.cnt = '0;
            if (sup_edge) begin
               d.st = ST_SYNC;
            end
         end
         ST_SYNC: begin
            // The sync bit is a zero: its one edge after the start closes it.
            d.cnt = q.cnt + 20'd1;
            if (sup_edge) begin
               if (q.cnt + 20'd1 >= 20'(SYNC_MIN_CYC) && q.cnt < 20'(SYNC_MAX_CYC)) begin
                  d.st = ST_BITS;
                  d.tbit = q.cnt + 20'd1;
               end else begin
                  d.st = ST_IDLE;
               end
               d.cnt = '0;
               d.nbits = '0;
               d.mid_seen = 1'b0;
            end else if (q.cnt >= 20'(SYNC_MAX_CYC)) begin
               d.st = ST_IDLE;
            end
         end
         ST_BITS: begin
            // Edges before seven eighths of a period are mid-bit changes, later ones close the bit.
            d.cnt = q.cnt + 20'd1;
            if (sup_edge && q.cnt < q.tbit - (q.tbit >> 3)) begin
               d.mid_seen = 1'b1;
               if (q.mid_seen || q.cnt < (q.tbit >> 2)) begin
                  d.st = ST_IDLE;
               end
            end else if (sup_edge) begin
               d.shreg = sh;
               d.nbits = nb;
               d.cnt = '0;
               d.mid_seen = 1'b0;
               if ((nb == `HDR_BITS && sh[8:6] != `CMD_WRITE) || nb == `WR_BITS) begin
                  d.st = ST_EXEC;
               end
            end else if (q.cnt > q.tbit + (q.tbit >> 1)) begin
               d.st = ST_IDLE;
            end
         end
         ST_EXEC: begin
            // A deactivated or locked sensor and a bad header both stay silent.
            if (hdr_ok && q.active && !q.dev_lock) begin
               case (cmd)
                  `CMD_READ: begin
                     ack = (wid != 4'd0);
                  end
                  `CMD_WRITE: begin
                     ack = pay_ok && sel_wr;
                     if (ack && sel == `SEL_DEACT) begin
                        d.active = (pw != `DEACT_VALUE);
                     end else if (ack) begin
                        d.ram[sel*14 +: 14] = pw;
                     end
                  end
                  `CMD_BURN, `CMD_ERASE: begin
                     ack = 1'b1;
                     d.burn_pend = 1'b1;
                     d.burn_erase = (cmd == `CMD_ERASE);
                  end
                  `CMD_FLOCK: begin
                     ack = 1'b1;
                  end
                  `CMD_LOCK: begin
                     ack = 1'b1;
                     d.dev_lock = 1'b1;
                  end
                  default: begin
                     ack = 1'b0;
                  end
               endcase
            end
            if (ack) begin
               d.st = ST_TX;
               d.tx_sh = (cmd == `CMD_READ) ? {1'b0, rd_word, ~^(~rd_word)} : 16'h0000;
               d.tx_left = (cmd == `CMD_READ) ? 5'd16 : 5'd1;
               d.out_oe = 1'b1;
               d.out_drive = 1'b1;
               d.tx_cnt = '0;
               d.tx_mid = 1'b0;
            end else begin
               d.st = ST_IDLE;
            end
         end
         ST_TX: begin
            // A one flips at five eighths of the period, inside the allowed window.
            d.tx_cnt = q.tx_cnt + 20'd1;
            if (!q.tx_mid && q.tx_sh[15] &&
                q.tx_cnt == (q.obit >> 1) + (q.obit >> 3)) begin
               d.out_drive = ~q.out_drive;
               d.tx_mid = 1'b1;
            end
            if (q.tx_cnt >= q.obit - 20'd1) begin
               d.out_drive = ~q.out_drive;
               d.tx_sh = {q.tx_sh[14:0], 1'b0};
               d.tx_left = q.tx_left - 5'd1;
               d.tx_cnt = '0;
               d.tx_mid = 1'b0;
               if (q.tx_left == 5'd1) begin
                  d.out_oe = 1'b0;
                  d.out_drive = 1'b0;
                  d.st = q.burn_pend ? ST_BURN : ST_IDLE;
                  d.cnt = '0;
               end
            end
         end
         ST_BURN: begin
            // The cells change on the first cycle at programming level; the lock cells never.
            d.cnt = q.cnt + 20'd1;
            d.burn_busy = q.prog_s[1];
            if (q.prog_s[1] && !q.burn_busy) begin
               for (int i = 0; i < 16; i++) begin
                  if (i != 6 && i != 14) begin
                     d.nv[i*14 +: 14] = q.burn_erase ? 14'h0000 : q.ram[i*14 +: 14];
                  end
               end
            end
            if ((q.burn_busy && !q.prog_s[1]) ||
                (!q.burn_busy && q.cnt >= 20'(BURN_WAIT_CYC))) begin
               d.st = ST_IDLE;
               d.burn_pend = 1'b0;
               d.burn_busy = 1'b0;
            end
         end
         default: begin
            d.st = ST_IDLE;
         end
      endcase
      // Activate pulse on a released pin; the sensor's own drive must not count as one.
      if (!q.active && !q.out_oe) begin
         d.act_cnt = q.pin_s[1] ? q.act_cnt + 20'd1 : '0;
         if (!q.pin_s[1] && q.pin_prev && q.act_cnt >= 20'(ACT_MIN_CYC) &&
             q.act_cnt <= 20'(ACT_MAX_CYC)) begin
            d.active = 1'b1;
         end
      end else begin
         d.act_cnt = '0;
      end
      // APB slave: data latched in setup, answered in the first access cycle.
      if (psel && !penable) begin
         d.pready = 1'b1;
         d.prdata = '0;
         if (paddr == `OFS_CTRL) begin
            d.prdata = {12'h000, q.obit};
         end else if (paddr == `OFS_STATUS) begin
            d.prdata = {23'h000000, q.burn_busy, q.analog_hold, q.st, q.out_oe,
                        q.fac_lock, q.dev_lock, q.active};
         end else if (paddr == `OFS_ADC) begin
            d.prdata = {18'h00000, q.adc};
         end else if (paddr >= `OFS_REGS && paddr < `OFS_REGS + 12'h040 && paddr[1:0] == 2'b00) begin
            d.prdata = {18'h00000, q.ram[paddr[5:2]*14 +: 14]};
         end else begin
            d.pslverr = 1'b1;
         end
         if (pwrite && paddr != `OFS_CTRL && paddr != `OFS_ADC) begin
            d.pslverr = 1'b1;
         end
      end
      if (psel && penable && q.pready && pwrite && !q.pslverr) begin
         if (paddr == `OFS_CTRL) begin
            d.obit = (pwdata[19:0] < 20'h00010) ? 20'h00010 : pwdata[19:0];
         end else begin
            d.adc = pwdata[13:0];
         end
      end
      // Undervoltage: analog output held while above the hold level, digital side parked and RAM reloaded from cells.
      d.analog_hold = !q.uv_s[1] && q.hold_s[1];
      if (!q.uv_s[1]) begin
         d.st = ST_START;
         d.cnt = '0;
         d.ram = q.nv;
         d.out_oe = 1'b0;
         d.out_drive = 1'b0;
         d.burn_pend = 1'b0;
         d.burn_busy = 1'b0;
      end
   end

   // ****************************************************************************
   // State register.
   // ****************************************************************************
   // The pin reset is the full reset below the lowest supply threshold.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= RST;
      end else begin
         q <= d;
      end
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign out_pin_out = q.out_drive;
   assign out_pin_oe = q.out_oe;
   assign analog_only = q.analog_only;
   assign analog_hold = q.analog_hold;
   assign burn_busy = q.burn_busy;

   // ****************************************************************************
   // Checks.
   // ****************************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_sync_reject;
      q.st == ST_SYNC && sup_edge && q.cnt >= 20'(SYNC_MAX_CYC) |=> q.st == ST_IDLE;
   endproperty
   a_sync_reject: assert property (p_sync_reject) else $error("bad sync accepted");
   property p_ack_zero;
      $rose(out_pin_oe) |-> out_pin_out ##1 (out_pin_oe && out_pin_out)[*8];
   endproperty
   a_ack_zero: assert property (p_ack_zero) else $error("acknowledge not a held zero");
   property p_bad_hdr;
      q.st == ST_EXEC && !hdr_ok |=> q.st == ST_IDLE ##1 !out_pin_oe;
   endproperty
   a_bad_hdr: assert property (p_bad_hdr) else $error("reply to bad parity");
   property p_write_ack;
      q.st == ST_EXEC && hdr_ok && q.active && !q.dev_lock && cmd == `CMD_WRITE && pay_ok &&
      sel_wr |=> $rose(out_pin_oe) && q.tx_left == 5'd1;
   endproperty
   a_write_ack: assert property (p_write_ack) else $error("valid write not acknowledged");
   property p_read_len;
      q.st == ST_EXEC && hdr_ok && q.active && !q.dev_lock && cmd == `CMD_READ &&
      wid != 4'd0 |=> q.tx_left == 5'd16;
   endproperty
   a_read_len: assert property (p_read_len) else $error("read reply length wrong");
   property p_inactive_silent;
      q.st == ST_EXEC && !q.active |=> !out_pin_oe;
   endproperty
   a_inactive_silent: assert property (p_inactive_silent) else $error("inactive replied");
   property p_uv_reset;
      !q.uv_s[1] |=> q.st == ST_START && !out_pin_oe;
   endproperty
   a_uv_reset: assert property (p_uv_reset) else $error("undervoltage ignored");
   property p_lock_analog;
      q.dev_lock |=> analog_only;
   endproperty
   a_lock_analog: assert property (p_lock_analog) else $error("lock not analog-only");
   property p_fac_lock;
      q.fac_lock;
   endproperty
   a_fac_lock: assert property (p_fac_lock) else $error("factory lock cleared");
   property p_tx_end;
      q.st == ST_TX && q.tx_left == 5'd1 && q.tx_cnt >= q.obit - 20'd1 && !q.burn_pend &&
      q.uv_s[1] |=> q.st == ST_IDLE && !out_pin_oe;
   endproperty
   a_tx_end: assert property (p_tx_end) else $error("receiver not rearmed");
   c_read: cover property (q.st == ST_EXEC && cmd == `CMD_READ ##1 q.st == ST_TX);
   c_burn: cover property ($rose(burn_busy));
   c_activate: cover property (!q.active ##1 q.active);
endmodule : supply_line_telegram_link
`default_nettype wire

// File: tb/telegram_programmer.sv
// Programmer model: sends telegrams to the sensor as supply-level changes.
// Assumes the bench calls send and idle; the level idles low between telegrams.
`timescale 1ns/1ps
`default_nettype none
module telegram_programmer #(
   parameter int T = 42
) (
   input wire logic pclk,
   output logic supply_level
);
   // ****
   // Telegram sender.
   // ****
   initial supply_level = 1'b0;
   // The sync bit sets the period; a one toggles at 27 of 42 cycles, inside 50-80 percent.
   task automatic send(input logic [23:0] b, input int n);
      int i;
      @(posedge pclk) supply_level <= ~supply_level;
      repeat (T) @(posedge pclk);
      supply_level <= ~supply_level;
      for (i = n - 1; i >= 0; i--) begin
         if (b[i]) begin
            repeat (27) @(posedge pclk);
            supply_level <= ~supply_level;
            repeat (T - 27) @(posedge pclk);
         end else begin
            repeat (T) @(posedge pclk);
         end
         supply_level <= ~supply_level;
      end
   endtask : send
   // Back to the low level once the reply is over, so the next rise starts a sync bit.
   task automatic idle();
      @(posedge pclk) supply_level <= 1'b0;
   endtask : idle
endmodule : telegram_programmer
`default_nettype wire

// File: tb/tb_supply_line_telegram_link.sv
// Bench for the telegram link: APB tasks, telegrams through the programmer model.
// Assumes the shortened link counts set at the instance below.
`timescale 1ns/1ps
`default_nettype none
`include "link_defines.svh"
module tb_supply_line_telegram_link;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e, got;
   logic dig = 1, hold = 1, at_prog = 0, act = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, rd;
   logic [13:0] d;
   logic [15:0] rep;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, sup, pin_out, pin_oe, pin_w, a_only, a_hold, busy;
   int n_errors = 0, checks_done = 0, cyc = 0, per, i, j;
   // ****
   // Clock, pin wire, design and programmer.
   // ****
   initial forever #2.5 pclk = ~pclk;
   // The pin is pulled down unless the sensor drives it or the bench sends an activate pulse.
   assign pin_w = pin_oe ? pin_out : act;
   // The output period comes from the CTRL write, so only the receive counts are shortened.
   supply_line_telegram_link #(.SYNC_MIN_CYC(40), .SYNC_MAX_CYC(44),
      .ACT_MIN_CYC(4), .ACT_MAX_CYC(16)) dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .supply_level(sup), .supply_above_digital(dig), .supply_above_hold(hold),
      .supply_at_prog(at_prog), .out_pin_in(pin_w), .out_pin_out(pin_out),
      .out_pin_oe(pin_oe), .analog_only(a_only), .analog_hold(a_hold), .burn_busy(busy));
   telegram_programmer prog (.pclk(pclk), .supply_level(sup));
   // ****
   // Tasks and functions.
   // ****
   task automatic finish_test();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test
   task automatic chk(input logic ok, input string m);
      checks_done++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask : chk
   // The request stands until pready is seen high at a rising edge; data are taken there.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(pready === 1'b1, "no bus answer");
   endtask : apb
   // Odd count of zeros gives a one; payload parity takes the inverse.
   function automatic logic par(input logic [13:0] v, input int w);
      return 1'((w - $countones(v)) & 1);
   endfunction : par
   task automatic tel(input logic [2:0] c, input logic [3:0] s, input logic [13:0] v,
      input logic bad);
      logic [23:0] b;
      b = {c, par(14'(c), 3) ^ bad, s, par(14'(s), 4), v, ~par(v, 14)};
      if (c == `CMD_WRITE) prog.send(b, 24);
      else prog.send(b >> 15, 9);
   endtask : tel
   // A bit is a one when the pin differs between a quarter and three quarters in.
   task automatic rx();
      logic a;
      got = 0;
      for (j = 0; j < 400 && !got; j++) @(negedge pclk) got = (pin_oe === 1'b1);
      for (j = 15; j >= 0 && got; j--) begin
         repeat (per / 4) @(negedge pclk);
         a = pin_out;
         repeat (per / 2) @(negedge pclk);
         rep[j] = a ^ pin_out;
         repeat (per - per / 4 - per / 2) @(negedge pclk);
      end
      for (j = 0; j < 2 * per && pin_oe === 1'b1; j++) @(negedge pclk);
      prog.idle();
      repeat (60) @(posedge pclk);
   endtask : rx
   // ****
   // Timeout and main sequence.
   // ****
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_errors++;
         finish_test();
      end
   end
   initial begin
      void'($urandom(33));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4100) @(posedge pclk);
      apb(0, `OFS_STATUS, 0);
      chk(rd[2:0] === 3'b101, "status after reset");
      apb(0, 12'h100, 0);
      chk(e === 1'b1, "unmapped address");
      apb(1, `OFS_STATUS, 0);
      chk(e === 1'b1, "write to read-only");
      per = 16 + $urandom_range(31);
      apb(1, `OFS_CTRL, per);
      for (i = 0; i < 3; i++) begin
         d = (i == 0) ? 14'h3FFF : 14'($urandom);
         tel(`CMD_WRITE, 4'h1, d, 0);
         rx();
         chk(got && rep[15] === 1'b0, "write acknowledge");
         apb(0, `OFS_REGS + 12'h004, 0);
         chk(rd[9:0] === d[9:0], "narrow write");
         tel(`CMD_READ, 4'h1, 0, 0);
         rx();
         chk(got && rep[14:5] === d[9:0], "narrow read");
         chk(rep[0] === ~par(rep[14:1], 14), "reply parity");
      end
      tel(`CMD_WRITE, 4'h1, ~d, 1);
      rx();
      chk(!got, "bad parity answered");
      apb(0, `OFS_REGS + 12'h004, 0);
      chk(rd[9:0] === d[9:0], "bad telegram executed");
      tel(3'h0, 4'h1, 0, 0);
      rx();
      chk(!got, "undefined command answered");
      // Burn the last good write into the cells while the supply sits at programming level.
      tel(`CMD_BURN, 4'h0, 0, 0);
      rx();
      chk(got && rep[15] === 1'b0, "burn acknowledge");
      at_prog <= 1'b1;
      repeat (10) @(posedge pclk);
      chk(busy === 1'b1, "burn not busy");
      at_prog <= 1'b0;
      repeat (10) @(posedge pclk);
      chk(busy === 1'b0, "burn stuck");
      // Spoil the RAM, then a digital undervoltage must reload it from the cells.
      tel(`CMD_WRITE, 4'h1, ~d, 0);
      rx();
      dig <= 1'b0;
      repeat (10) @(posedge pclk);
      chk(a_hold === 1'b1, "analog output not held");
      dig <= 1'b1;
      repeat (4100) @(posedge pclk);
      chk(a_hold === 1'b0, "hold not released");
      apb(0, `OFS_REGS + 12'h004, 0);
      chk(rd[9:0] === d[9:0], "cells not reloaded");
      // Deactivate, stay silent, then come back on an activate pulse at the pin.
      tel(`CMD_WRITE, `SEL_DEACT, `DEACT_VALUE, 0);
      rx();
      chk(got && rep[15] === 1'b0, "deactivate acknowledge");
      tel(`CMD_READ, 4'h1, 0, 0);
      rx();
      chk(!got, "inactive sensor answered");
      act <= 1'b1;
      repeat (10) @(posedge pclk);
      act <= 1'b0;
      repeat (5) @(posedge pclk);
      apb(0, `OFS_STATUS, 0);
      chk(rd[0] === 1'b1, "activate pulse ignored");
      tel(`CMD_READ, 4'h1, 0, 0);
      rx();
      chk(got && rep[14:5] === d[9:0], "read after activate");
      // The lock is final: analog-only, and no further replies.
      tel(`CMD_LOCK, 4'h0, 0, 0);
      rx();
      chk(got && a_only === 1'b1, "lock not analog-only");
      tel(`CMD_READ, 4'h1, 0, 0);
      rx();
      chk(!got, "locked sensor answered");
      finish_test();
   end
endmodule : tb_supply_line_telegram_link
`default_nettype wire
